// file: hdl/crs_regset.sv
`timescale 1ns/10ps
`include "crs_cfg.svh"
// Behaviour
// RULE_01: Eight-bit accumulator for ALU operands, results
// RULE_02: Two index registers; second survives interrupt frames
// RULE_03: Sixteen-bit instruction pointer, low and high
// RULE_04: Flag word resets 111x1xxx, pushable, poppable
// RULE_05: Half carry from bit3 on add
// RULE_06: Sign flag copies result bit seven
// RULE_07: Zero flag set on zero result
// RULE_08: Carry on overflow, shifts, set/clear ops
// RULE_09: Two mask bits encode priority levels
// RULE_10: Mask bits loaded on entry, ops
// RULE_11: Stack pointer points free; post-dec, pre-inc
// RULE_12: 256-byte stack, fixed high, reload sets
// RULE_13: Stack pointer low byte directly loadable
// RULE_14: Stack pointer wraps silently both ways
// RULE_15: Interrupt saves low pointer byte first
// RULE_16: Call uses two bytes, interrupt five
// RULE_17: Flag bits seven, six read one
module crs_regset (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  crs_pkg::crs_core_type r_r;
  crs_pkg::crs_core_type r_nxt;
  logic                  mem_we;
  logic [7:0]            mem_waddr;
  logic [7:0]            mem_wdata;
  logic [7:0]            mem_raddr;
  logic [7:0]            mem_rdata;

  // Word-aligned byte address
  function automatic logic [7:0] word_addr(input logic [7:0] a);
    word_addr = {a[7:2], 2'b00};
  endfunction : word_addr

  // Known register offsets
  function automatic logic is_mapped(input logic [7:0] a);
    case (word_addr(a))
      `CRS_OFF_ACC, `CRS_OFF_IDX_X, `CRS_OFF_IDX_Y, `CRS_OFF_IP,
      `CRS_OFF_FLAGS, `CRS_OFF_STACK, `CRS_OFF_OPERAND, `CRS_OFF_CMD,
      `CRS_OFF_STATUS, `CRS_OFF_PRIO, `CRS_OFF_TARGET, `CRS_OFF_POPPED:
        is_mapped = 1'b1;
      default:
        is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // Byte lane merge under strobes
  function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] new_b, input logic strb);
    lane = strb ? new_b : old;
  endfunction : lane

  // Byte saved in a given frame slot
  function automatic logic [7:0] slot_byte(input logic [2:0] slot, input crs_pkg::crs_core_type s);
    case (slot)
      `CRS_SLOT_IPL: slot_byte = s.instr_pointer[7:0];
      `CRS_SLOT_IPH: slot_byte = s.instr_pointer[15:8];
      `CRS_SLOT_X:   slot_byte = s.idx_x;
      `CRS_SLOT_A:   slot_byte = s.acc;
      default:       slot_byte = s.flag_word_reg;
    endcase
  endfunction : slot_byte

  // Stack memory, 256 bytes
  crs_stack_mem #(
    .DEPTH (256),
    .AW    (8)
  ) u_stack (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .we       (mem_we),
    .waddr    (mem_waddr),
    .wdata    (mem_wdata),
    .raddr    (mem_raddr),
    .rdata    (mem_rdata)
  );

  // Bus slave, command execution and stack sequencer
  always_comb
  begin
    logic [8:0]  sum;
    logic [4:0]  half;
    logic [7:0]  res;
    logic        cin;
    logic        busy;
    logic [2:0]  slot;
    logic [7:0]  rd;
    crs_pkg::crs_cmd_type cmd;
    sum = '0;
    half = '0;
    res = '0;
    cin = 1'b0;
    slot = '0;
    rd = '0;
    cmd = crs_pkg::CMD_NOP;
    busy = (r_r.st != crs_pkg::ST_IDLE);
    r_nxt = r_r;
    mem_we = 1'b0;
    mem_waddr = r_r.stack_ptr_lo;
    mem_wdata = slot_byte(r_r.base + r_r.step, r_r);
    mem_raddr = r_r.stack_ptr_lo + 8'h01;

    // Ready lines rise once after reset
    if (!r_r.init)
    begin
      r_nxt.init = 1'b1;
      r_nxt.awready = 1'b1;
      r_nxt.wready = 1'b1;
      r_nxt.arready = 1'b1;
    end

    // Write address and data taken in either order
    if (s_axi_awvalid && r_r.awready)
    begin
      r_nxt.aw_full = 1'b1;
      r_nxt.waddr = s_axi_awaddr;
      r_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid && r_r.wready)
    begin
      r_nxt.w_full = 1'b1;
      r_nxt.wdata = s_axi_wdata;
      r_nxt.wstrb = s_axi_wstrb;
      r_nxt.wready = 1'b0;
    end

    // Response retires, slave reopens
    if (r_r.bvalid && s_axi_bready)
    begin
      r_nxt.bvalid = 1'b0;
      r_nxt.awready = 1'b1;
      r_nxt.wready = 1'b1;
    end

    // Register write once both halves held
    if (r_r.aw_full && r_r.w_full && !r_r.bvalid)
    begin
      r_nxt.aw_full = 1'b0;
      r_nxt.w_full = 1'b0;
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp = is_mapped(r_r.waddr) ? `CRS_RESP_OKAY : `CRS_RESP_SLVERR;
      if (!busy)
      begin
        case (word_addr(r_r.waddr))
          // RULE_01 accumulator write
          `CRS_OFF_ACC:     r_nxt.acc = lane(r_r.acc, r_r.wdata[7:0], r_r.wstrb[0]);
          `CRS_OFF_IDX_X:   r_nxt.idx_x = lane(r_r.idx_x, r_r.wdata[7:0], r_r.wstrb[0]);
          `CRS_OFF_IDX_Y:   r_nxt.idx_y = lane(r_r.idx_y, r_r.wdata[7:0], r_r.wstrb[0]);
          `CRS_OFF_IP:
          begin
            // RULE_03 separate pointer halves
            r_nxt.instr_pointer[7:0] = lane(r_r.instr_pointer[7:0], r_r.wdata[7:0], r_r.wstrb[0]);
            r_nxt.instr_pointer[15:8] = lane(r_r.instr_pointer[15:8], r_r.wdata[15:8], r_r.wstrb[1]);
          end
          // RULE_17 fixed ones kept
          `CRS_OFF_FLAGS:   r_nxt.flag_word_reg = lane(r_r.flag_word_reg, r_r.wdata[7:0], r_r.wstrb[0])
                                                | `CRS_CC_FIXED;
          // RULE_13 direct low byte load
          `CRS_OFF_STACK:   r_nxt.stack_ptr_lo = lane(r_r.stack_ptr_lo, r_r.wdata[7:0], r_r.wstrb[0]);
          `CRS_OFF_OPERAND: r_nxt.operand = lane(r_r.operand, r_r.wdata[7:0], r_r.wstrb[0]);
          `CRS_OFF_PRIO:    r_nxt.prio_level_regs = r_r.wstrb[0] ? r_r.wdata[1:0] : r_r.prio_level_regs;
          `CRS_OFF_TARGET:
          begin
            r_nxt.target[7:0] = lane(r_r.target[7:0], r_r.wdata[7:0], r_r.wstrb[0]);
            r_nxt.target[15:8] = lane(r_r.target[15:8], r_r.wdata[15:8], r_r.wstrb[1]);
          end
          `CRS_OFF_CMD:
          begin
            if (r_r.wstrb[0])
            begin
              cmd = crs_pkg::crs_cmd_type'(r_r.wdata[4:0]);
            end
          end
          default:
          begin
          end
        endcase
      end
    end

    // Command execution
    r_nxt.kind = cmd;
    r_nxt.step = 3'd0;
    case (cmd)
      crs_pkg::CMD_ADD, crs_pkg::CMD_ADC:
      begin
        cin = (cmd == crs_pkg::CMD_ADC) ? r_r.flag_word_reg[`CRS_CC_C] : 1'b0;
        sum = {1'b0, r_r.acc} + {1'b0, r_r.operand} + {8'h00, cin};
        half = {1'b0, r_r.acc[3:0]} + {1'b0, r_r.operand[3:0]} + {4'h0, cin};
        res = sum[7:0];
        // RULE_05 carry out of bit three
        r_nxt.flag_word_reg[`CRS_CC_H] = half[4];
        // RULE_08 carry on overflow
        r_nxt.flag_word_reg[`CRS_CC_C] = sum[8];
      end
      crs_pkg::CMD_SUB:
      begin
        sum = {1'b0, r_r.acc} - {1'b0, r_r.operand};
        res = sum[7:0];
        // RULE_08 borrow on underflow
        r_nxt.flag_word_reg[`CRS_CC_C] = sum[8];
      end
      crs_pkg::CMD_AND: res = r_r.acc & r_r.operand;
      crs_pkg::CMD_LD:  res = r_r.operand;
      crs_pkg::CMD_ROL:
      begin
        res = {r_r.acc[6:0], r_r.flag_word_reg[`CRS_CC_C]};
        // RULE_08 rotate through carry
        r_nxt.flag_word_reg[`CRS_CC_C] = r_r.acc[7];
      end
      // RULE_08 direct carry set, clear
      crs_pkg::CMD_SCF: r_nxt.flag_word_reg[`CRS_CC_C] = 1'b1;
      crs_pkg::CMD_RCF: r_nxt.flag_word_reg[`CRS_CC_C] = 1'b0;
      // RULE_10 software mask updates
      crs_pkg::CMD_RIM, crs_pkg::CMD_HALT, crs_pkg::CMD_WFI:
        {r_nxt.flag_word_reg[`CRS_CC_I1], r_nxt.flag_word_reg[`CRS_CC_I0]} = `CRS_PRIO_MAIN;
      // RULE_09 level three disables
      crs_pkg::CMD_SIM:
        {r_nxt.flag_word_reg[`CRS_CC_I1], r_nxt.flag_word_reg[`CRS_CC_I0]} = `CRS_PRIO_OFF;
      // RULE_12 reload to stack top
      crs_pkg::CMD_RSP: r_nxt.stack_ptr_lo = `CRS_SP_RESET_LO;
      crs_pkg::CMD_PUSH_A, crs_pkg::CMD_PUSH_CC:
      begin
        r_nxt.st = crs_pkg::ST_PUSH;
        r_nxt.cnt = `CRS_FRAME_BYTE;
        r_nxt.base = (cmd == crs_pkg::CMD_PUSH_A) ? `CRS_SLOT_A : `CRS_SLOT_CC;
      end
      crs_pkg::CMD_POP_A, crs_pkg::CMD_POP_CC:
      begin
        r_nxt.st = crs_pkg::ST_POP_RD;
        r_nxt.cnt = `CRS_FRAME_BYTE;
        r_nxt.base = (cmd == crs_pkg::CMD_POP_A) ? `CRS_SLOT_A : `CRS_SLOT_CC;
      end
      // RULE_16 frame sizes
      crs_pkg::CMD_CALL, crs_pkg::CMD_IRQ:
      begin
        r_nxt.st = crs_pkg::ST_PUSH;
        r_nxt.cnt = (cmd == crs_pkg::CMD_CALL) ? `CRS_FRAME_CALL : `CRS_FRAME_IRQ;
        r_nxt.base = `CRS_SLOT_IPL;
      end
      crs_pkg::CMD_RET, crs_pkg::CMD_HANDLER_RETURN_OP:
      begin
        r_nxt.st = crs_pkg::ST_POP_RD;
        r_nxt.cnt = (cmd == crs_pkg::CMD_RET) ? `CRS_FRAME_CALL : `CRS_FRAME_IRQ;
        r_nxt.base = `CRS_SLOT_IPL;
      end
      default:
      begin
        r_nxt.kind = r_r.kind;
        r_nxt.step = r_r.step;
      end
    endcase

    // Result flags for data operations
    case (cmd)
      crs_pkg::CMD_ADD, crs_pkg::CMD_ADC, crs_pkg::CMD_SUB,
      crs_pkg::CMD_AND, crs_pkg::CMD_LD, crs_pkg::CMD_ROL:
      begin
        r_nxt.acc = res;
        // RULE_06 sign from bit seven
        r_nxt.flag_word_reg[`CRS_CC_N] = res[7];
        // RULE_07 zero result
        r_nxt.flag_word_reg[`CRS_CC_Z] = (res == 8'h00);
      end
      default:
      begin
      end
    endcase

    // Stack sequencer
    case (r_r.st)
      crs_pkg::ST_PUSH:
      begin
        // RULE_15 first byte at pointer
        mem_we = 1'b1;
        // RULE_11 decrement after push
        // RULE_14 silent eight-bit wrap
        r_nxt.stack_ptr_lo = r_r.stack_ptr_lo - 8'h01;
        r_nxt.step = r_r.step + 3'd1;
        if (r_r.step == r_r.cnt - 3'd1)
        begin
          r_nxt.st = crs_pkg::ST_IDLE;
          if (r_r.kind == crs_pkg::CMD_IRQ || r_r.kind == crs_pkg::CMD_CALL)
          begin
            r_nxt.instr_pointer = r_r.target;
          end
          if (r_r.kind == crs_pkg::CMD_IRQ)
          begin
            // RULE_10 mask from level registers
            {r_nxt.flag_word_reg[`CRS_CC_I1], r_nxt.flag_word_reg[`CRS_CC_I0]} = r_r.prio_level_regs;
          end
        end
      end
      crs_pkg::ST_POP_RD:
      begin
        // RULE_11 increment before pop
        r_nxt.stack_ptr_lo = r_r.stack_ptr_lo + 8'h01;
        r_nxt.st = crs_pkg::ST_POP_WR;
      end
      crs_pkg::ST_POP_WR:
      begin
        rd = mem_rdata;
        slot = r_r.base + r_r.cnt - 3'd1 - r_r.step;
        r_nxt.popped = rd;
        // RULE_02 second index never in frame
        case (slot)
          `CRS_SLOT_IPL: r_nxt.instr_pointer[7:0] = rd;
          `CRS_SLOT_IPH: r_nxt.instr_pointer[15:8] = rd;
          `CRS_SLOT_X:   r_nxt.idx_x = rd;
          `CRS_SLOT_A:   r_nxt.acc = rd;
          // RULE_04 flag word popped
          default:       r_nxt.flag_word_reg = rd | `CRS_CC_FIXED;
        endcase
        r_nxt.step = r_r.step + 3'd1;
        r_nxt.st = (r_r.step == r_r.cnt - 3'd1) ? crs_pkg::ST_IDLE : crs_pkg::ST_POP_RD;
      end
      default:
      begin
      end
    endcase

    // Read channel
    if (r_r.rvalid && s_axi_rready)
    begin
      r_nxt.rvalid = 1'b0;
      r_nxt.arready = 1'b1;
    end
    if (s_axi_arvalid && r_r.arready)
    begin
      r_nxt.arready = 1'b0;
      r_nxt.rvalid = 1'b1;
      r_nxt.rresp = is_mapped(s_axi_araddr) ? `CRS_RESP_OKAY : `CRS_RESP_SLVERR;
      r_nxt.rdata = 32'h0000_0000;
      case (word_addr(s_axi_araddr))
        `CRS_OFF_ACC:     r_nxt.rdata[7:0] = r_r.acc;
        `CRS_OFF_IDX_X:   r_nxt.rdata[7:0] = r_r.idx_x;
        `CRS_OFF_IDX_Y:   r_nxt.rdata[7:0] = r_r.idx_y;
        `CRS_OFF_IP:      r_nxt.rdata[15:0] = r_r.instr_pointer;
        // RULE_17 top bits read one
        `CRS_OFF_FLAGS:   r_nxt.rdata[7:0] = r_r.flag_word_reg | `CRS_CC_FIXED;
        // RULE_12 fixed high byte
        `CRS_OFF_STACK:   r_nxt.rdata[15:0] = {`CRS_SP_HIGH, r_r.stack_ptr_lo};
        `CRS_OFF_OPERAND: r_nxt.rdata[7:0] = r_r.operand;
        `CRS_OFF_STATUS:  r_nxt.rdata[0] = busy;
        `CRS_OFF_PRIO:    r_nxt.rdata[1:0] = r_r.prio_level_regs;
        `CRS_OFF_TARGET:  r_nxt.rdata[15:0] = r_r.target;
        `CRS_OFF_POPPED:  r_nxt.rdata[7:0] = r_r.popped;
        default:
        begin
        end
      endcase
    end
  end

  // State register with documented reset values
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r_r <= '0;
      // RULE_04 flag word reset
      r_r.flag_word_reg <= `CRS_CC_RESET;
      // RULE_12 pointer low bits set
      r_r.stack_ptr_lo <= `CRS_SP_RESET_LO;
      r_r.instr_pointer <= `CRS_IP_RESET;
      r_r.st <= crs_pkg::ST_IDLE;
      r_r.kind <= crs_pkg::CMD_NOP;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  // Bus outputs straight from state
  assign s_axi_awready = r_r.awready;
  assign s_axi_wready  = r_r.wready;
  assign s_axi_bvalid  = r_r.bvalid;
  assign s_axi_bresp   = r_r.bresp;
  assign s_axi_arready = r_r.arready;
  assign s_axi_rvalid  = r_r.rvalid;
  assign s_axi_rresp   = r_r.rresp;
  assign s_axi_rdata   = r_r.rdata;

endmodule : crs_regset

// file: hdl/crs_cfg.svh
`ifndef CRS_CFG_SVH
`define CRS_CFG_SVH

// Bus geometry and responses
`define CRS_ADDR_W       8
`define CRS_RESP_OKAY    2'b00
`define CRS_RESP_SLVERR  2'b10

// Register byte offsets
`define CRS_OFF_ACC      8'h00
`define CRS_OFF_IDX_X    8'h04
`define CRS_OFF_IDX_Y    8'h08
`define CRS_OFF_IP       8'h0C
`define CRS_OFF_FLAGS    8'h10
`define CRS_OFF_STACK    8'h14
`define CRS_OFF_OPERAND  8'h18
`define CRS_OFF_CMD      8'h1C
`define CRS_OFF_STATUS   8'h20
`define CRS_OFF_PRIO     8'h24
`define CRS_OFF_TARGET   8'h28
`define CRS_OFF_POPPED   8'h2C

// Flag word bit positions
`define CRS_CC_C         0
`define CRS_CC_Z         1
`define CRS_CC_N         2
`define CRS_CC_I0        3
`define CRS_CC_H         4
`define CRS_CC_I1        5
`define CRS_CC_FIXED     8'hC0

// Reset values (undefined flag bits taken as zero)
`define CRS_CC_RESET     8'hE8
`define CRS_SP_RESET_LO  8'hFF
`define CRS_SP_HIGH      8'h01
`define CRS_IP_RESET     16'h0000

// Priority mask encodings {high bit, low bit}
`define CRS_PRIO_MAIN    2'b10
`define CRS_PRIO_OFF     2'b11

// Stack frame slots and sizes
`define CRS_SLOT_IPL     3'd0
`define CRS_SLOT_IPH     3'd1
`define CRS_SLOT_X       3'd2
`define CRS_SLOT_A       3'd3
`define CRS_SLOT_CC      3'd4
`define CRS_FRAME_IRQ    3'd5
`define CRS_FRAME_CALL   3'd2
`define CRS_FRAME_BYTE   3'd1

`endif

// file: hdl/crs_pkg.sv
package crs_pkg;

  // Commands written to the command register, coded in listed order
  typedef enum logic [4:0] {
    CMD_NOP, CMD_ADD, CMD_ADC, CMD_SUB, CMD_AND, CMD_LD, CMD_ROL,
    CMD_SCF, CMD_RCF, CMD_RIM, CMD_SIM, CMD_HALT, CMD_WFI, CMD_RSP,
    CMD_PUSH_A, CMD_POP_A, CMD_PUSH_CC, CMD_POP_CC, CMD_CALL, CMD_RET,
    CMD_IRQ, CMD_HANDLER_RETURN_OP
  } crs_cmd_type;

  // Stack sequencer states
  typedef enum logic [1:0] {
    ST_IDLE, ST_PUSH, ST_POP_RD, ST_POP_WR
  } crs_state_type;

  // Whole state of the register set
  typedef struct packed {
    logic          init;
    logic          awready;
    logic          wready;
    logic          arready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
    logic          aw_full;
    logic          w_full;
    logic [7:0]    waddr;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic [7:0]    acc;
    logic [7:0]    idx_x;
    logic [7:0]    idx_y;
    logic [15:0]   instr_pointer;
    logic [7:0]    flag_word_reg;
    logic [7:0]    stack_ptr_lo;
    logic [7:0]    operand;
    logic [15:0]   target;
    logic [1:0]    prio_level_regs;
    logic [7:0]    popped;
    crs_state_type st;
    crs_cmd_type   kind;
    logic [2:0]    step;
    logic [2:0]    cnt;
    logic [2:0]    base;
  } crs_core_type;

endpackage : crs_pkg

// file: hdl/crs_stack_mem.sv
`timescale 1ns/10ps
module crs_stack_mem #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          arst_n,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  // Registered read port
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [7:0]            rdata;
  } crs_mem_type;

  crs_mem_type r_r;
  crs_mem_type r_nxt;

  // Write one byte, read one byte a cycle later
  always_comb
  begin
    r_nxt = r_r;
    r_nxt.rdata = r_r.mem[raddr];
    if (we)
    begin
      r_nxt.mem[waddr] = wdata;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r_r <= '0;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  assign rdata = r_r.rdata;

endmodule : crs_stack_mem

// file: tb/crs_regset_assertions.sv
`timescale 1ns/10ps
`include "crs_cfg.svh"
module crs_regset_chk (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        arst_n,
  // Write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read channels
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  logic [7:0] ra_r;
  logic       rd_ok;

  // Address of the read in flight
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      ra_r <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready)
      ra_r <= s_axi_araddr;
  end

  // Good read data on the bus
  assign rd_ok = s_axi_rvalid && (s_axi_rresp == `CRS_RESP_OKAY);

  a_read_turn: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  a_flag_ones: assert property (rd_ok && ra_r == `CRS_OFF_FLAGS |-> s_axi_rdata[31:6] == 26'h000_0003)
    else $error("flag word top bits wrong");
  a_stack_page: assert property (rd_ok && ra_r == `CRS_OFF_STACK |-> s_axi_rdata[31:8] == 24'h00_0001)
    else $error("stack page wrong");
  a_byte_regs: assert property (rd_ok && ra_r inside {`CRS_OFF_ACC, `CRS_OFF_IDX_X, `CRS_OFF_IDX_Y}
    |-> s_axi_rdata[31:8] == 24'h00_0000) else $error("byte register too wide");
  a_ip_width: assert property (rd_ok && ra_r == `CRS_OFF_IP |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("pointer too wide");
  a_unmapped_read: assert property (s_axi_rvalid && ra_r >= 8'h30
    |-> s_axi_rresp == `CRS_RESP_SLVERR && s_axi_rdata == 32'h0000_0000) else $error("hole not refused");

  c_flags_read: cover property (rd_ok && ra_r == `CRS_OFF_FLAGS);
  c_slow_read: cover property (s_axi_rvalid && !s_axi_rready);
  c_write_err: cover property (s_axi_bvalid && s_axi_bresp == `CRS_RESP_SLVERR);
endmodule : crs_regset_chk

bind crs_regset crs_regset_chk u_chk (
  .core_clk, .arst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);

// file: tb/cpu_core_register_set_tb.sv
`timescale 1ns/10ps
`include "crs_cfg.svh"
module cpu_core_register_set_tb;
  logic        core_clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, slow;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          err_total, n_tests, cyc;
  logic [7:0]  ofs[4] = '{`CRS_OFF_ACC, `CRS_OFF_IDX_X, `CRS_OFF_IDX_Y, `CRS_OFF_IP};
  logic [31:0] msk[4] = '{32'h0000_00FF, 32'h0000_00FF, 32'h0000_00FF, 32'h0000_FFFF};
  logic [4:0]  al[6] = '{crs_pkg::CMD_SCF, crs_pkg::CMD_RCF, crs_pkg::CMD_SCF, crs_pkg::CMD_LD,
                         crs_pkg::CMD_ROL, crs_pkg::CMD_SUB};
  logic [31:0] af[6] = '{32'h0000_00C5, 32'h0000_00C4, 32'h0000_00C5, 32'h0000_00C5, 32'h0000_00C1, 32'h0000_00C5};
  logic [4:0]  ml[3] = '{crs_pkg::CMD_HALT, crs_pkg::CMD_WFI, crs_pkg::CMD_RIM};

  crs_regset dut (
    .core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  // Clock
  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Bus write; slow delays bready
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ta, tw, tb, hb;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !slow;
    forever
    begin
      @(negedge core_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      hb = s_axi_bready;
      rs = s_axi_bresp;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb && hb)
      begin
        s_axi_bready <= 1'b0;
        break;
      end
      if (tb) s_axi_bready <= 1'b1;
    end
  endtask : wr

  // Bus read; slow delays rready
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ta, tr, hr;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !slow;
    forever
    begin
      @(negedge core_clk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      hr = s_axi_rready;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr && hr)
      begin
        s_axi_rready <= 1'b0;
        break;
      end
      if (tr) s_axi_rready <= 1'b1;
    end
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk(d, e);
  endtask : rc

  task automatic wc(input logic [7:0] a, input logic [31:0] v);
    wr(a, v, r);
    chk(32'(r), 32'(`CRS_RESP_OKAY));
  endtask : wc

  // Issue a command and wait out busy
  task automatic cmd(input logic [4:0] c);
    wc(`CRS_OFF_CMD, 32'(c));
    do rd(`CRS_OFF_STATUS, d, r); while (d[0] !== 1'b0);
  endtask : cmd

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  // Hang guard
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      end_of_test();
    end
  end

  initial
  begin
    arst_n = 1'b0;
    slow = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    rc(`CRS_OFF_ACC, 32'h0000_0000);
    rc(`CRS_OFF_FLAGS, 32'h0000_00E8);
    rc(`CRS_OFF_STACK, 32'h0000_01FF);
    foreach (ofs[i])
    begin
      wc(ofs[i], 32'hFFFF_FFFF);
      rc(ofs[i], msk[i]);
    end
    wc(`CRS_OFF_FLAGS, 32'h0000_0000);
    rc(`CRS_OFF_FLAGS, 32'h0000_00C0);
    wr(8'h30, 32'h1234_5678, r);
    chk(32'(r), 32'(`CRS_RESP_SLVERR));
    rc(8'h30, 32'h0000_0000);
    chk(32'(r), 32'(`CRS_RESP_SLVERR));
    $display("Test registers finished");
    wc(`CRS_OFF_ACC, 32'h0000_000F);
    wc(`CRS_OFF_OPERAND, 32'h0000_0001);
    cmd(crs_pkg::CMD_ADD);
    rc(`CRS_OFF_FLAGS, 32'h0000_00D0);
    wc(`CRS_OFF_ACC, 32'h0000_0080);
    wc(`CRS_OFF_OPERAND, 32'h0000_0080);
    cmd(crs_pkg::CMD_ADD);
    rc(`CRS_OFF_FLAGS, 32'h0000_00C3);
    cmd(crs_pkg::CMD_ADC);
    rc(`CRS_OFF_ACC, 32'h0000_0081);
    rc(`CRS_OFF_FLAGS, 32'h0000_00C4);
    foreach (al[i])
    begin
      cmd(al[i]);
      rc(`CRS_OFF_FLAGS, af[i]);
    end
    rc(`CRS_OFF_ACC, 32'h0000_0081);
    cmd(crs_pkg::CMD_AND);
    rc(`CRS_OFF_ACC, 32'h0000_0080);
    rc(`CRS_OFF_FLAGS, 32'h0000_00C5);
    foreach (ml[i])
    begin
      cmd(crs_pkg::CMD_SIM);
      rc(`CRS_OFF_FLAGS, 32'h0000_00ED);
      cmd(ml[i]);
      rc(`CRS_OFF_FLAGS, 32'h0000_00E5);
    end
    $display("Test flags finished");
    slow = 1'b1;
    wc(`CRS_OFF_STACK, 32'h0000_0000);
    rc(`CRS_OFF_STACK, 32'h0000_0100);
    wc(`CRS_OFF_ACC, 32'h0000_003C);
    cmd(crs_pkg::CMD_PUSH_A);
    rc(`CRS_OFF_STACK, 32'h0000_01FF);
    wc(`CRS_OFF_ACC, 32'h0000_0000);
    cmd(crs_pkg::CMD_POP_A);
    rc(`CRS_OFF_STACK, 32'h0000_0100);
    rc(`CRS_OFF_POPPED, 32'h0000_003C);
    cmd(crs_pkg::CMD_RSP);
    rc(`CRS_OFF_STACK, 32'h0000_01FF);
    cmd(crs_pkg::CMD_PUSH_CC);
    wc(`CRS_OFF_FLAGS, 32'h0000_0000);
    cmd(crs_pkg::CMD_POP_CC);
    rc(`CRS_OFF_FLAGS, 32'h0000_00E5);
    wc(`CRS_OFF_IP, 32'h0000_ABCD);
    wc(`CRS_OFF_TARGET, 32'h0000_1234);
    cmd(crs_pkg::CMD_CALL);
    rc(`CRS_OFF_STACK, 32'h0000_01FD);
    cmd(crs_pkg::CMD_RET);
    rc(`CRS_OFF_IP, 32'h0000_ABCD);
    wc(`CRS_OFF_IDX_X, 32'h0000_0011);
    wc(`CRS_OFF_IDX_Y, 32'h0000_005A);
    wc(`CRS_OFF_PRIO, 32'h0000_0001);
    cmd(crs_pkg::CMD_IRQ);
    rc(`CRS_OFF_FLAGS, 32'h0000_00CD);
    rc(`CRS_OFF_STACK, 32'h0000_01FA);
    rc(`CRS_OFF_IDX_Y, 32'h0000_005A);
    wc(`CRS_OFF_IDX_X, 32'h0000_0000);
    wc(`CRS_OFF_ACC, 32'h0000_0000);
    wc(`CRS_OFF_IDX_Y, 32'h0000_00A5);
    cmd(crs_pkg::CMD_HANDLER_RETURN_OP);
    rc(`CRS_OFF_FLAGS, 32'h0000_00E5);
    rc(`CRS_OFF_IDX_X, 32'h0000_0011);
    rc(`CRS_OFF_ACC, 32'h0000_003C);
    rc(`CRS_OFF_IDX_Y, 32'h0000_00A5);
    rc(`CRS_OFF_IP, 32'h0000_ABCD);
    wc(`CRS_OFF_STACK, 32'h0000_00FE);
    cmd(crs_pkg::CMD_POP_A);
    rc(`CRS_OFF_ACC, 32'h0000_00CD);
    $display("Test stack finished");
    @(posedge core_clk);
    arst_n <= 1'b0;
    @(posedge core_clk);
    arst_n <= 1'b1;
    rc(`CRS_OFF_STACK, 32'h0000_01FF);
    rc(`CRS_OFF_FLAGS, 32'h0000_00E8);
    $display("Test second reset finished");
    end_of_test();
  end
endmodule : cpu_core_register_set_tb
